// >>> design/wpd_regs.vh
// Register map, field positions and constants of the wake-up detector
`ifndef WPD_REGS_VH
`define WPD_REGS_VH

// ********************************
// Word indices (byte address = 4 * index)
// ********************************
`define WPD_IDX_CTRL 4'h0
`define WPD_IDX_ADDR_LO 4'h1
`define WPD_IDX_ADDR_HI 4'h2
`define WPD_IDX_MASK_BASE 4'h4
`define WPD_IDX_CMD 4'h8
`define WPD_IDX_OFFSET 4'h9
`define WPD_IDX_CRC01 4'ha
`define WPD_IDX_CRC23 4'hb

// ********************************
// Control and status fields
// ********************************
`define WPD_BIT_PAT_EN 0
`define WPD_BIT_FRM_EN 1
`define WPD_BIT_RPT_PME 2
`define WPD_BIT_PAT_RCV 4
`define WPD_BIT_FRM_RCV 5
`define WPD_BIT_SLEEP 8

// ********************************
// Filter fields
// ********************************
`define WPD_CMD_ENABLE 0
`define WPD_CMD_MCAST 3
`define WPD_CMD_W 4
`define WPD_OFS_W 8
`define WPD_CRC_W 16
`define WPD_MASK_LEN 31

// ********************************
// Pattern and CRC constants
// ********************************
`define WPD_SYNC_BYTE 8'hff
`define WPD_SYNC_LEN 3'h6
`define WPD_ADDR_LEN 3'h6
`define WPD_REPS 5'h10
`define WPD_HDR_LEN 11'h00c
`define WPD_CRC_POLY 16'h8005
`define WPD_CRC_INIT 16'hffff
`define WPD_POS_MAX 11'h7ff

`endif

// >>> design/wpd_sync.v
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module wpd_sync (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Level
    input wire d_i,
    output reg q_o
);
    reg meta_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            meta_ff <= d_i;
            q_o <= meta_ff;
        end
    end
endmodule

// >>> design/wpd_crc16.v
// Byte-wise CRC-16 accumulator for one wake-up frame filter
`timescale 1ns/1ps
`include "wpd_regs.vh"
module wpd_crc16 (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Byte stream
    input wire clr_i,
    input wire en_i,
    input wire [7:0] data_i,
    // Result
    output reg [15:0] crc_o
);
    reg [15:0] nxt_crc;
    reg fb;
    integer k;

    // MSB-first shift, one byte per cycle
    always @* begin
        nxt_crc = clr_i ? `WPD_CRC_INIT : crc_o;
        fb = 1'b0;
        if (en_i) begin
            for (k = 7; k >= 0; k = k - 1) begin
                fb = nxt_crc[15] ^ data_i[k];
                nxt_crc = {nxt_crc[14:0], 1'b0};
                if (fb) begin
                    nxt_crc = nxt_crc ^ `WPD_CRC_POLY;
                end
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            crc_o <= `WPD_CRC_INIT;
        end else if (ce_i) begin
            crc_o <= nxt_crc;
        end
    end
endmodule

// >>> design/wpd_top.v
// Wake-up frame filters and wake pattern detector with Wishbone registers
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "wpd_regs.vh"
module wpd_top #(
    parameter NUM_FILT = 4,
    parameter POS_W = 11
) (
    // Clock, reset, clock enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Receive byte stream from the MAC, same clock
    input wire rx_valid_i,
    input wire rx_sof_i,
    input wire rx_eof_i,
    input wire [7:0] rx_data_i,
    // Power state pin, light_sleep_state when high
    input wire light_sleep_i,
    // Reporting
    output reg irq_o,
    output reg power_event_o,
    output reg rx_suppress_o
);
    // ********************************
    // Registers
    // ********************************
    reg pat_en_ff;
    reg frm_en_ff;
    reg rpt_pme_ff;
    reg pat_rcv_ff;
    reg frm_rcv_ff;
    reg [47:0] station_ff;
    reg [30:0] mask_ff [0:NUM_FILT-1];
    reg [4*NUM_FILT-1:0] cmd_ff;
    reg [8*NUM_FILT-1:0] ofs_ff;
    reg [16*NUM_FILT-1:0] crc_exp_ff;
    wire sleep_s;
    integer i;
    wpd_sync u_sleep_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(light_sleep_i),
        .q_o(sleep_s)
    );

    // Light sleep overrides both enables
    wire pat_act = pat_en_ff | sleep_s;
    wire frm_act = frm_en_ff | sleep_s;

    // ********************************
    // Wishbone slave, one wait state
    // ********************************
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire [3:0] widx = wb_adr_i[5:2];
    wire wb_hit = wb_req & ~wb_ack_o;
    wire wr_now = wb_hit & wb_we_i;
    wire in_mask = (widx >= `WPD_IDX_MASK_BASE) &&
        (widx < `WPD_IDX_MASK_BASE + NUM_FILT) && (wb_adr_i[7:6] == 2'h0);
    wire [1:0] midx = widx[1:0];
    wire reg_sel = (wb_adr_i[7:6] == 2'h0);

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge[8*b +: 8] = nw[8*b +: 8];
                end
            end
        end
    endfunction

    wire [31:0] ctrl_rd = {23'h000000, sleep_s, 2'h0, frm_rcv_ff,
        pat_rcv_ff, 1'b0, rpt_pme_ff, frm_en_ff, pat_en_ff};
    reg [31:0] rd_data;
    always @* begin
        rd_data = 32'h00000000;
        if (in_mask) begin
            rd_data = {1'b0, mask_ff[midx]};
        end else if (reg_sel) begin
            case (widx)
                `WPD_IDX_CTRL: rd_data = ctrl_rd;
                `WPD_IDX_ADDR_LO: rd_data = station_ff[31:0];
                `WPD_IDX_ADDR_HI: rd_data = {16'h0000, station_ff[47:32]};
                `WPD_IDX_CMD: rd_data = {16'h0000, cmd_ff};
                `WPD_IDX_OFFSET: rd_data = ofs_ff;
                `WPD_IDX_CRC01: rd_data = crc_exp_ff[31:0];
                `WPD_IDX_CRC23: rd_data = crc_exp_ff[63:32];
                default: rd_data = 32'h00000000;
            endcase
        end
    end

    // ********************************
    // Receive position tracking
    // ********************************
    reg [POS_W-1:0] pos_ff;
    reg da_own_ff;
    reg da_bcast_ff;
    reg da_mcast_ff;
    reg eof_d_ff;
    wire [POS_W-1:0] pos = rx_sof_i ? {POS_W{1'b0}} : pos_ff;
    wire byte_v = rx_valid_i;
    wire [2:0] da_i = pos[2:0];
    wire da_byte = byte_v && (pos < `WPD_ADDR_LEN);
    wire own_b = (rx_data_i == station_ff[8*da_i +: 8]);
    wire bc_b = (rx_data_i == `WPD_SYNC_BYTE);
    wire own_acc = rx_sof_i ? 1'b1 : da_own_ff;
    wire bc_acc = rx_sof_i ? 1'b1 : da_bcast_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            pos_ff <= {POS_W{1'b0}};
            da_own_ff <= 1'b0;
            da_bcast_ff <= 1'b0;
            da_mcast_ff <= 1'b0;
            eof_d_ff <= 1'b0;
        end else if (ce_i) begin
            eof_d_ff <= byte_v & rx_eof_i;
            if (byte_v) begin
                if (pos != `WPD_POS_MAX) begin
                    pos_ff <= pos + 1'b1;
                end
                if (da_byte) begin
                    da_own_ff <= own_acc & own_b;
                    da_bcast_ff <= bc_acc & bc_b;
                end
                if (rx_sof_i) begin
                    da_mcast_ff <= rx_data_i[0];
                end
            end
        end
    end
    wire is_mcast = da_mcast_ff & ~da_bcast_ff;

    // ********************************
    // Wake-up frame filters
    // ********************************
    wire [NUM_FILT-1:0] filt_hit;
    genvar g;
    generate
        for (g = 0; g < NUM_FILT; g = g + 1) begin : g_filt
            wire [15:0] crc_cur;
            wire [POS_W-1:0] ofs = {{(POS_W-`WPD_OFS_W){1'b0}},
                ofs_ff[8*g +: 8]};
            wire [POS_W-1:0] rel = pos - ofs;
            wire in_win = (pos >= ofs) && (rel < `WPD_MASK_LEN) &&
                mask_ff[g][rel[4:0]];
            wire [3:0] cmd = cmd_ff[4*g +: 4];
            wire type_ok = cmd[`WPD_CMD_MCAST] ? is_mcast :
                da_own_ff;

            wpd_crc16 u_crc (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .clr_i(byte_v & rx_sof_i),
                .en_i(byte_v & in_win),
                .data_i(rx_data_i),
                .crc_o(crc_cur)
            );

            assign filt_hit[g] = eof_d_ff & frm_act & cmd[`WPD_CMD_ENABLE] &
                type_ok & (crc_cur == crc_exp_ff[16*g +: 16]);
        end
    endgenerate

    // ********************************
    // Wake pattern search
    // ********************************
    localparam ST_HDR = 4'h1;
    localparam ST_SYNC = 4'h2;
    localparam ST_REP = 4'h4;
    localparam ST_DONE = 4'h8;
    reg [3:0] st_ff;
    reg [2:0] ffcnt_ff;
    reg [2:0] aidx_ff;
    reg [4:0] rep_ff;
    wire [7:0] exp_b = station_ff[8*aidx_ff +: 8];
    wire is_ff = (rx_data_i == `WPD_SYNC_BYTE);
    wire sync_full = (ffcnt_ff == `WPD_SYNC_LEN);
    // Own, broadcast or multicast destination may carry the pattern
    wire dest_ok = da_own_ff | da_bcast_ff | is_mcast;
    wire pat_hit = eof_d_ff & pat_act & (st_ff == ST_DONE) & dest_ok;

    always @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= ST_HDR;
            ffcnt_ff <= 3'h0;
            aidx_ff <= 3'h0;
            rep_ff <= 5'h00;
        end else if (ce_i && byte_v) begin
            if (rx_sof_i) begin
                st_ff <= ST_HDR;
                ffcnt_ff <= 3'h0;
            end else begin
                case (st_ff)
                    ST_HDR: begin
                        // Sync search starts after both addresses
                        if (pos == `WPD_HDR_LEN - 1'b1) begin
                            st_ff <= ST_SYNC;
                        end
                    end
                    ST_SYNC: begin
                        if (is_ff) begin
                            if (!sync_full) begin
                                ffcnt_ff <= ffcnt_ff + 1'b1;
                            end
                        end else if (sync_full &&
                                rx_data_i == station_ff[7:0]) begin
                            st_ff <= ST_REP;
                            aidx_ff <= 3'h1;
                            rep_ff <= 5'h00;
                        end else begin
                            ffcnt_ff <= 3'h0;
                        end
                    end
                    ST_REP: begin
                        if (rx_data_i != exp_b) begin
                            // A stray byte may itself open a new sync run
                            st_ff <= ST_SYNC;
                            ffcnt_ff <= is_ff ? 3'h1 : 3'h0;
                        end else if (aidx_ff == `WPD_ADDR_LEN - 1'b1) begin
                            aidx_ff <= 3'h0;
                            rep_ff <= rep_ff + 1'b1;
                            if (rep_ff == `WPD_REPS - 1'b1) begin
                                st_ff <= ST_DONE;
                            end
                        end else begin
                            aidx_ff <= aidx_ff + 1'b1;
                        end
                    end
                    ST_DONE: st_ff <= ST_DONE;
                    default: st_ff <= ST_HDR;
                endcase
            end
        end
    end

    // ********************************
    // Register writes, status and outputs
    // ********************************
    wire [31:0] wr_data = merge(rd_data, wb_dat_i, wb_sel_i);
    wire ctrl_wr = wr_now && reg_sel && (widx == `WPD_IDX_CTRL);

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            pat_en_ff <= 1'b0;
            frm_en_ff <= 1'b0;
            rpt_pme_ff <= 1'b0;
            pat_rcv_ff <= 1'b0;
            frm_rcv_ff <= 1'b0;
            station_ff <= 48'h000000000000;
            cmd_ff <= {4*NUM_FILT{1'b0}};
            ofs_ff <= {8*NUM_FILT{1'b0}};
            crc_exp_ff <= {16*NUM_FILT{1'b0}};
            for (i = 0; i < NUM_FILT; i = i + 1) begin
                mask_ff[i] <= 31'h00000000;
            end
            irq_o <= 1'b0;
            power_event_o <= 1'b0;
            rx_suppress_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_hit;
            if (wb_hit) begin
                wb_dat_o <= rd_data;
            end
            if (ctrl_wr) begin
                pat_en_ff <= wr_data[`WPD_BIT_PAT_EN];
                frm_en_ff <= wr_data[`WPD_BIT_FRM_EN];
                rpt_pme_ff <= wr_data[`WPD_BIT_RPT_PME];
            end
            // Write one to clear; a detection in the same cycle wins
            pat_rcv_ff <= pat_hit | (pat_rcv_ff & ~(ctrl_wr &
                wb_sel_i[0] & wb_dat_i[`WPD_BIT_PAT_RCV]));
            frm_rcv_ff <= (|filt_hit) | (frm_rcv_ff & ~(ctrl_wr &
                wb_sel_i[0] & wb_dat_i[`WPD_BIT_FRM_RCV]));
            // Merging over the read value keeps unselected byte lanes
            if (wr_now && reg_sel) begin
                case (widx)
                    `WPD_IDX_ADDR_LO: station_ff[31:0] <= wr_data;
                    `WPD_IDX_ADDR_HI: station_ff[47:32] <= wr_data[15:0];
                    `WPD_IDX_CMD: cmd_ff <= wr_data[15:0];
                    `WPD_IDX_OFFSET: ofs_ff <= wr_data;
                    `WPD_IDX_CRC01: crc_exp_ff[31:0] <= wr_data;
                    `WPD_IDX_CRC23: crc_exp_ff[63:32] <= wr_data;
                    default: begin
                    end
                endcase
            end
            if (wr_now && in_mask) begin
                mask_ff[midx] <= wr_data[30:0]; // Bit 31 reads zero
            end
            // Status stays visible until software clears it
            irq_o <= ~rpt_pme_ff & (pat_rcv_ff | frm_rcv_ff);
            power_event_o <= rpt_pme_ff & (pat_rcv_ff | frm_rcv_ff);
            rx_suppress_o <= pat_en_ff;
        end
    end
endmodule

// >>> verification/wpd_checker.sv
// Port assertions for the wake-up detector
`timescale 1ns/1ps
module wpd_checker (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Receive stream and reporting
    input wire rx_valid_i,
    input wire rx_eof_i,
    input wire irq_o,
    input wire power_event_o,
    input wire rx_suppress_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    property p_suppress;
        logic d;
        (req && wb_we_i && wb_adr_i[7:2] == 6'h0 && wb_sel_i[0],
            d = wb_dat_i[0]) |-> ##3 rx_suppress_o == d;
    endproperty

    chk_ack_next: assert property (req |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_unmapped_zero: assert property (req && !wb_we_i &&
        wb_adr_i[7:6] != 2'h0 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_suppress_follow: assert property (p_suppress)
        else $error("suppress does not follow enable");
    chk_suppress_cause: assert property ($changed(rx_suppress_o) |->
        $past(wb_cyc_i && wb_we_i, 2) || $past(wb_cyc_i && wb_we_i, 3))
        else $error("suppress moved without write");
    chk_report_one: assert property (!(irq_o && power_event_o))
        else $error("both report outputs high");
    chk_report_late: assert property ($rose(irq_o || power_event_o)
        |-> $past(rx_valid_i && rx_eof_i, 3))
        else $error("report not tied to frame end");

    cover property ($rose(irq_o));
    cover property ($rose(power_event_o));
    cover property ($fell(rx_suppress_o));
endmodule

bind wpd_top wpd_checker i_wpd_checker (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .rx_valid_i, .rx_eof_i, .irq_o, .power_event_o,
    .rx_suppress_o);

// >>> verification/wpd_rx_model.sv
// Receive byte stream model standing in for the MAC datapath
`timescale 1ns/1ps
module wpd_rx_model (
    // Clock
    input wire clk_i,
    // Byte stream
    output logic rx_valid_o,
    output logic rx_sof_o,
    output logic rx_eof_o,
    output logic [7:0] rx_data_o
);
    logic [7:0] fq[$];

    initial begin
        rx_valid_o = 1'b0;
        rx_sof_o = 1'b0;
        rx_eof_o = 1'b0;
        rx_data_o = 8'h00;
    end

    // Entered just after a rising edge; idle data is inverted so a
    // stale byte never looks valid
    task automatic send(input logic slow);
        for (int k = 0; k < fq.size(); k++) begin
            if (slow && k % 3 == 1) begin
                rx_valid_o <= 1'b0;
                rx_data_o <= ~rx_data_o;
                @(posedge clk_i);
            end
            rx_valid_o <= 1'b1;
            rx_sof_o <= k == 0;
            rx_eof_o <= k == fq.size() - 1;
            rx_data_o <= fq[k];
            @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_sof_o <= 1'b0;
        rx_eof_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
    endtask
endmodule

// >>> verification/wpd_top_tb.sv
// Self-checking testbench of the wake-up detector
`timescale 1ns/1ps
module wpd_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic light_sleep_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, r;
    logic wb_ack_o, rx_valid_i, rx_sof_i, rx_eof_i;
    logic irq_o, power_event_o, rx_suppress_o;
    logic [7:0] rx_data_i;
    logic [7:0] fr[$];
    logic [47:0] sta;
    int n_errors = 0;
    int num_checks = 0;

    wpd_top i_wpd_top (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .rx_valid_i, .rx_sof_i, .rx_eof_i, .rx_data_i, .light_sleep_i,
        .irq_o, .power_event_o, .rx_suppress_o);
    wpd_rx_model i_wpd_rx_model (.clk_i, .rx_valid_o(rx_valid_i),
        .rx_sof_o(rx_sof_i), .rx_eof_o(rx_eof_i), .rx_data_o(rx_data_i));

    initial forever #10 clk_i = ~clk_i;

    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        int t;
        t = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && t++ < 50);
        if (t >= 50) n_errors++;
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // MSB first, poly 8005, start all ones, over masked bytes
    function automatic logic [15:0] crc16(int ofs, logic [30:0] m);
        logic [15:0] c;
        c = 16'hffff;
        for (int j = 0; j < 31; j++)
            if (m[j])
                for (int b = 7; b >= 0; b--)
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[ofs+j][b]) ?
                        16'h8005 : 16'h0000);
        return c;
    endfunction

    task automatic add(input int n);
        repeat (n) for (int k = 0; k < 6; k++) fr.push_back(sta[8*k+:8]);
    endtask

    // Sends the frame, lets the verdict settle, reads control and status
    task automatic sendr;
        i_wpd_rx_model.fq = fr;
        i_wpd_rx_model.send(1'($urandom % 2));
        repeat (4) @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
    endtask

    task automatic pat(input int da, nff, nrep,
        input logic brk, en, ls, rpt, exp);
        fr.delete();
        for (int k = 0; k < 6; k++)
            fr.push_back(da == 1 ? 8'hff : da == 2 ? {7'h0, k == 0} :
                sta[8*k+:8] ^ {7'h0, da == 3 && k == 5});
        repeat (6 + $urandom % 9) fr.push_back(8'($urandom % 255));
        if (brk) begin
            repeat (6) fr.push_back(8'hff);
            add(3);
            fr.push_back(sta[7:0] ^ 8'h01);
        end
        repeat (nff) fr.push_back(8'hff);
        add(nrep);
        repeat (4) fr.push_back(8'($urandom % 255));
        wb(1'b1, 8'h00, {29'h0, rpt, 1'b0, en});
        repeat (2) @(posedge clk_i);
        chk(rx_suppress_o, en);
        light_sleep_i <= ls;
        repeat (4) @(posedge clk_i);
        sendr;
        chk(r[8:4], {ls, 3'h0, exp});
        chk({irq_o, power_event_o}, {exp & ~rpt, exp & rpt});
        wb(1'b1, 8'h00, 32'h30);
        light_sleep_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({irq_o, power_event_o}, 2'b00);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        int f, v;
        logic mc;
        logic [31:0] ofs, msk;
        logic [15:0] c;
        void'($urandom(93));
        for (int k = 0; k < 6; k++) sta[8*k+:8] = 8'($urandom % 255);
        sta[0] = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h0);
        wb(1'b1, 8'h40, $urandom);
        wb(1'b0, 8'h40, 32'h0);
        chk(r, 32'h0);
        wb(1'b1, 8'h04, sta[31:0]);
        wb(1'b1, 8'h08, {16'($urandom), sta[47:32]});
        wb(1'b0, 8'h08, 32'h0);
        chk(r, {16'h0, sta[47:32]});
        // Byte lane 1 alone clears one station byte, then it is restored
        wb_sel_i <= 4'h2;
        wb(1'b1, 8'h08, 32'h0);
        wb_sel_i <= 4'hf;
        wb(1'b0, 8'h08, 32'h0);
        chk(r, {24'h0, sta[39:32]});
        wb(1'b1, 8'h08, {16'h0, sta[47:32]});
        // Args: dest kind, sync bytes, copies, break, en, sleep, pme, hit
        pat(0, 6, 16, 0, 1, 0, 0, 1);
        pat(1, 7, 16, 1, 1, 0, 1, 1);
        pat(2, 6, 16, 0, 1, 0, 0, 1);
        pat(3, 6, 16, 0, 1, 0, 1, 0);
        pat(0, 5, 16, 0, 1, 0, 0, 0);
        pat(0, 6, 15, 0, 1, 0, 1, 0);
        pat(0, 6, 16, 0, 0, 0, 0, 0);
        pat(0, 6, 16, 0, 0, 1, 1, 1);
        // Each case across the four filters in turn: match, bad byte, frames off, wrong type
        for (int k = 0; k < 16; k++) begin
            f = k % 4;
            v = k / 4;
            mc = 1'($urandom % 2);
            ofs = 12 + $urandom % 20;
            msk = $urandom | 32'h1;
            fr.delete();
            for (int j = 0; j < 64; j++) fr.push_back(8'($urandom));
            if (mc) fr[0][0] = 1'b1;
            else for (int j = 0; j < 6; j++) fr[j] = sta[8*j+:8];
            c = crc16(ofs, msk[30:0]);
            wb(1'b1, 8'h10 + 8'(4 * f), msk);
            wb(1'b0, 8'h10 + 8'(4 * f), 32'h0);
            chk(r, msk & 32'h7fffffff);
            wb(1'b1, 8'h20, ((mc ^ (v == 3)) ? 32'h9 : 32'h1) << 4 * f);
            wb(1'b1, 8'h24, ofs << 8 * f);
            wb(1'b1, 8'h28 + 8'(4 * (f / 2)), {16'h0, c} << 16 * (f % 2));
            if (v == 1) fr[ofs] = ~fr[ofs];
            wb(1'b1, 8'h00, v == 2 ? 32'h0 : 32'h2);
            sendr;
            chk(r[5:4], {v == 0, 1'b0});
            wb(1'b1, 8'h00, 32'h30);
        end
        summarize;
    end

    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        summarize;
    end
endmodule
